// ==== inc/sioa_params.svh ====
// Constants for the slave I/O word allocator
// Function
// - Two, four or eight host words supported
// - Eight or four bits per node
// - Input and output node numbers independent
// - Eight-bit mode: node n in word n/2
// - Word group base follows mounting position; here the bases are fixed at SIOA_ADDR_IN0 and SIOA_ADDR_OUT0
// - Sixteen-bit slave pairs two nodes, one word
// - Four-bit slave uses low nibble of byte
// - Wide slaves in eight-bit mode take consecutive nodes from even
// - Overflowing slave excluded, link indicator dark
// - 32-bit connector slave takes four nodes
// - 16-bit connector slave as ordinary 16-bit
// - I/O valid after host cycle plus delay
// - No status-area words given to host
// - Two switch bits select word allocation
// - Third switch bit selects per-node size
// - Four-bit mode: nibble per node, byte pairs
`ifndef SIOA_PARAMS_SVH
`define SIOA_PARAMS_SVH
// Register indices on the host port
`define SIOA_ADDR_IN0      4'h0
`define SIOA_ADDR_OUT0     4'h4
`define SIOA_ADDR_STATUS   4'h8
`define SIOA_ADDR_MASK     4'h9
`define SIOA_ADDR_CONFIG   4'hA
// Status bit positions
`define SIOA_STS_EXCLUDED  0
`define SIOA_STS_VALID     1
`define SIOA_STS_W         2
// Allocation codes after switch decode
`define SIOA_ALLOC_2W      2'h0
`define SIOA_ALLOC_4W      2'h1
`define SIOA_ALLOC_8W      2'h2
// Startup delay
`define SIOA_CLK_KHZ       25000
`define SIOA_FAST_MS       118
`define SIOA_LONG_MS       720
`define SIOA_FAST_CYCLES   (`SIOA_FAST_MS * `SIOA_CLK_KHZ)
`define SIOA_LONG_CYCLES   (`SIOA_LONG_MS * `SIOA_CLK_KHZ)
`define SIOA_CNT_W         25
`endif

// ==== inc/sioa_pkg.sv ====
// Types for the slave I/O word allocator
package sioa_pkg;
	// Startup sequence states
	typedef enum logic [1:0] {
		ST_CAPTURE,
		ST_WAIT,
		ST_SYNC,
		ST_READY
	} sioa_state_e;
endpackage : sioa_pkg

// ==== logic/sioa_word_allocator.sv ====
// Slave I/O word allocator: places slave data into host input and output words
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "sioa_params.svh"
module sioa_word_allocator #(
	parameter int unsigned FAST_CYCLES = `SIOA_FAST_CYCLES,
	parameter int unsigned LONG_CYCLES = `SIOA_LONG_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        swAllocLo,
	input  wire logic        swAllocHi,
	input  wire logic        swFourPoint,
	input  wire logic        swLongDist,
	input  wire logic        hostCycle,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	input  wire logic        slvStb,
	input  wire logic        slvIsOut,
	input  wire logic [3:0]  slvNode,
	input  wire logic [6:0]  slvBits,
	input  wire logic [63:0] slvInData,
	output logic      [63:0] slvOutData,
	output logic      [63:0] slvDriveMask,
	output logic             slvAck,
	output logic             linkOkIndicator,
	output logic             ioValid,
	output logic             irq
);
	// First unit of a slave; wide slaves in byte mode snap to the even node
	function automatic logic [4:0] startUnit(input logic [3:0] node, input logic [6:0] bits,
		input logic mode4);
		if (!mode4 && bits >= 7'd16)
			return {1'b0, node[3:1], 1'b0};
		return {1'b0, node};
	endfunction : startUnit

	// Units occupied, rounded up; connector slaves follow the same count
	function automatic logic [4:0] unitCount(input logic [6:0] bits, input logic mode4);
		logic [7:0] u;
		u = mode4 ? ({1'b0, bits} + 8'd3) >> 2 : ({1'b0, bits} + 8'd7) >> 3;
		return u[4:0];
	endfunction : unitCount

	// Bit mask of len bits starting at off
	function automatic logic [63:0] placeMask(input logic [6:0] off, input logic [6:0] len);
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < 64; i++)
			m[i] = (7'(i) >= off) && ({1'b0, 7'(i)} < {1'b0, off} + {1'b0, len});
		return m;
	endfunction : placeMask

	sioa_pkg::sioa_state_e stateQ;
	logic [1:0]                   allocCode_q;
	logic                         mode4_q;
	logic                         longMode_q;
	logic [`SIOA_CNT_W-1:0]       waitCnt_q;
	logic [63:0]                  inImg_q;
	logic [63:0]                  outImg_q;
	logic [`SIOA_STS_W-1:0]       sts_q;
	logic [`SIOA_STS_W-1:0]       mask_q;
	logic [3:0]                   chkNode_q;

	// Switch decode and area size
	wire logic [1:0]  allocDecode = swAllocHi ? `SIOA_ALLOC_8W :
		(swAllocLo ? `SIOA_ALLOC_4W : `SIOA_ALLOC_2W);
	wire logic [6:0]  areaBits    = (allocCode_q == `SIOA_ALLOC_8W) ? 7'd64 :
		((allocCode_q == `SIOA_ALLOC_4W) ? 7'd32 : 7'd16);
	wire logic [4:0]  areaUnits   = mode4_q ? areaBits[6:2] : {1'b0, areaBits[6:3]};

	// Placement of the slave currently on the strobe
	wire logic [4:0]  plStart  = startUnit(slvNode, slvBits, mode4_q);
	wire logic [6:0]  plLen    = (slvBits > 7'd64) ? 7'd64 : slvBits;
	wire logic [4:0]  plCount  = unitCount(plLen, mode4_q); // Clamped so the unit count cannot wrap
	wire logic [5:0]  plEnd    = {1'b0, plStart} + {1'b0, plCount};
	wire logic        plFits   = plEnd <= {1'b0, areaUnits};
	wire logic [6:0]  plOff    = mode4_q ? {plStart, 2'b00} : {plStart[3:0], 3'b000};
	wire logic [63:0] plMask   = placeMask(plOff, plLen);
	wire logic        isReady  = (stateQ == sioa_pkg::ST_READY);
	wire logic        accept   = slvStb && isReady && plFits;
	wire logic        accIn    = accept && !slvIsOut;
	wire logic        accOut   = accept && slvIsOut;
	wire logic        excluded = slvStb && isReady && !plFits;

	// Register port decode
	wire logic        wrOut    = regWr && (regAddr[3:2] == `SIOA_ADDR_OUT0 >> 2);
	wire logic        wrSts    = regWr && (regAddr == `SIOA_ADDR_STATUS);
	wire logic        wrMask   = regWr && (regAddr == `SIOA_ADDR_MASK);
	wire logic [63:0] outWrMask = {48'h0000_0000_0000, 16'hFFFF} << {regAddr[1:0], 4'b0000};
	wire logic [63:0] outWrData = {48'h0000_0000_0000, regWdata} << {regAddr[1:0], 4'b0000};
	wire logic [63:0] inSel     = inImg_q >> {regAddr[1:0], 4'b0000};
	wire logic [63:0] outSel    = outImg_q >> {regAddr[1:0], 4'b0000};

	// Read mux; only the in and out word groups and our control words exist
	logic [15:0] readMux;
	always_comb begin
		case (regAddr)
			4'h0, 4'h1, 4'h2, 4'h3: readMux = inSel[15:0];
			4'h4, 4'h5, 4'h6, 4'h7: readMux = outSel[15:0];
			`SIOA_ADDR_STATUS: readMux = {14'h0000, sts_q};
			`SIOA_ADDR_MASK:   readMux = {14'h0000, mask_q};
			`SIOA_ADDR_CONFIG: readMux = {11'h000, ioValid, longMode_q, mode4_q, allocCode_q};
			default:           readMux = 16'h0000;
		endcase
	end

	// Events: set wins over a write-one clear in the same cycle
	wire logic [`SIOA_STS_W-1:0] evt    = {(stateQ == sioa_pkg::ST_SYNC) && hostCycle, excluded};
	wire logic [`SIOA_STS_W-1:0] clrSts = wrSts ? regWdata[`SIOA_STS_W-1:0] : '0;
	wire logic [`SIOA_STS_W-1:0] sts_d  = (sts_q & ~clrSts) | evt;

	// Delay load chosen by the communication mode
	wire logic [`SIOA_CNT_W-1:0] waitLoad = swLongDist ? `SIOA_CNT_W'(LONG_CYCLES) :
		`SIOA_CNT_W'(FAST_CYCLES);

	// Startup: catch switches after reset, wait the delay, then one host cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stateQ      <= sioa_pkg::ST_CAPTURE;
			allocCode_q <= `SIOA_ALLOC_2W;
			mode4_q     <= 1'b0;
			longMode_q  <= 1'b0;
			waitCnt_q   <= '0;
		end else begin
			case (stateQ)
				sioa_pkg::ST_CAPTURE: begin
					allocCode_q <= allocDecode;
					mode4_q     <= swFourPoint;
					longMode_q  <= swLongDist;
					waitCnt_q   <= waitLoad;
					stateQ      <= sioa_pkg::ST_WAIT;
				end
				sioa_pkg::ST_WAIT: begin
					if (waitCnt_q <= `SIOA_CNT_W'(1))
						stateQ <= sioa_pkg::ST_SYNC;
					waitCnt_q <= waitCnt_q - `SIOA_CNT_W'(1);
				end
				sioa_pkg::ST_SYNC: begin
					if (hostCycle)
						stateQ <= sioa_pkg::ST_READY;
				end
				sioa_pkg::ST_READY: stateQ <= sioa_pkg::ST_READY;
				default:            stateQ <= sioa_pkg::ST_CAPTURE;
			endcase
		end
	end

	// Input image: only the slave's own bits change, the rest keep their values
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			inImg_q <= 64'h0000_0000_0000_0000;
		else if (accIn)
			inImg_q <= (inImg_q & ~plMask) | ((slvInData << plOff) & plMask);
	end

	// Output image written by the host word by word
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			outImg_q <= 64'h0000_0000_0000_0000;
		else if (wrOut)
			outImg_q <= (outImg_q & ~outWrMask) | outWrData;
	end

	// Answer to the slave side; bits outside the slave are not driven
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			slvOutData      <= 64'h0000_0000_0000_0000;
			slvDriveMask    <= 64'h0000_0000_0000_0000;
			slvAck          <= 1'b0;
			linkOkIndicator <= 1'b0;
			chkNode_q       <= 4'h0;
		end else begin
			slvAck       <= slvStb;
			slvOutData   <= accOut ? (outImg_q & plMask) >> plOff : 64'h0000_0000_0000_0000;
			slvDriveMask <= accOut ? plMask >> plOff : 64'h0000_0000_0000_0000;
			if (slvStb) begin
				linkOkIndicator <= accept;
				chkNode_q       <= slvNode;
			end
		end
	end

	// Status, mask, interrupt, validity and register read data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sts_q    <= '0;
			mask_q   <= '0;
			irq      <= 1'b0;
			ioValid  <= 1'b0;
			regRdata <= 16'h0000;
		end else begin
			sts_q    <= sts_d;
			if (wrMask)
				mask_q <= regWdata[`SIOA_STS_W-1:0];
			irq      <= |(sts_d & (wrMask ? regWdata[`SIOA_STS_W-1:0] : mask_q));
			ioValid  <= (stateQ == sioa_pkg::ST_READY) || ((stateQ == sioa_pkg::ST_SYNC) && hostCycle);
			regRdata <= regRd ? readMux : 16'h0000;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// Views of the input image at the node last strobed
	wire logic [63:0] inByteChk = inImg_q >> {chkNode_q, 3'b000};
	wire logic [63:0] inWordChk = inImg_q >> {chkNode_q[3:1], 4'b0000};
	wire logic [63:0] inNibChk  = inImg_q >> {chkNode_q, 2'b00};

	sequence seqCapture;
		rst_b && stateQ == sioa_pkg::ST_CAPTURE; // Release edge still shows reset values
	endsequence
	sequence seqAcceptIn;
		slvStb && isReady && plFits && !slvIsOut;
	endsequence
	sequence seqStbReady;
		slvStb && isReady;
	endsequence

	AST_ALLOC_DECODE: assert property (seqCapture |=> allocCode_q ==
		($past(swAllocHi) ? `SIOA_ALLOC_8W : ($past(swAllocLo) ? `SIOA_ALLOC_4W : `SIOA_ALLOC_2W)))
		else $error("word allocation decode wrong");
	AST_POINT_MODE: assert property (seqCapture |=> mode4_q == $past(swFourPoint))
		else $error("point mode not taken from switch");
	AST_EXCLUDE: assert property (slvStb && isReady && !plFits |=> !linkOkIndicator && sts_q[0]
		&& slvDriveMask == 64'h0000_0000_0000_0000)
		else $error("overflowing slave not excluded");
	AST_UNTOUCHED: assert property (seqAcceptIn |=> ((inImg_q ^ $past(inImg_q)) & ~$past(plMask)) == 0)
		else $error("input bits outside slave changed");
	AST_EVEN_BYTE: assert property (seqAcceptIn ##0 (slvBits == 7'd8 && !mode4_q) |=>
		inByteChk[7:0] == $past(slvInData[7:0]))
		else $error("byte slave placed at wrong node");
	AST_PAIR_WORD: assert property (seqAcceptIn ##0 (slvBits == 7'd16 && !mode4_q) |=>
		inWordChk[15:0] == $past(slvInData[15:0]))
		else $error("sixteen-bit slave not in one word");
	AST_STARTUP: assert property ($rose(ioValid) |-> $past(stateQ) == sioa_pkg::ST_SYNC
		&& $past(hostCycle) && waitCnt_q == 0)
		else $error("inputs valid before startup delay");
	AST_NOT_READY: assert property (!ioValid && slvStb |=>
		!linkOkIndicator && (!sts_q[0] || $past(sts_q[0])))
		else $error("slave served before startup");
	// Level interrupt tracks status and mask with no lag visible to software
	AST_IRQ: assert property (irq == |(sts_q & mask_q))
		else $error("interrupt does not follow status and mask");

	// Slave side handshake: one answer per strobe, link result held between strobes
	AST_ACK_PULSE: assert property (slvStb |=> slvAck)
		else $error("slave strobe not acknowledged");
	AST_ACK_QUIET: assert property (!slvStb |=> !slvAck)
		else $error("acknowledge without a strobe");
	AST_LINK_HOLD: assert property (!slvStb |=> $stable(linkOkIndicator))
		else $error("link indicator changed without a strobe");

	// Only the slave's own bits are driven; input slaves get nothing
	AST_DRIVE_INSIDE: assert property (seqStbReady |=>
		(slvOutData & ~slvDriveMask) == 64'h0000_0000_0000_0000)
		else $error("output data outside the drive mask");
	AST_IN_NO_DRIVE: assert property (slvStb && !slvIsOut |=>
		slvDriveMask == 64'h0000_0000_0000_0000)
		else $error("drive mask raised toward an input slave");

	// Refused slaves never touch the input image; cycles without a strobe leave the output data at zero
	AST_IN_REFUSED: assert property (slvStb && !(isReady && plFits) |=> $stable(inImg_q))
		else $error("refused slave changed the input image");
	AST_OUT_IDLE: assert property (!slvStb |=> slvOutData == 64'h0000_0000_0000_0000)
		else $error("output data without a strobe");

	// Node range limits per slave size and word allocation
	AST_SIZE_LIMIT: assert property (seqStbReady ##0 (!mode4_q &&
		((slvBits == 7'd64 && allocCode_q != `SIOA_ALLOC_8W) ||
		(slvBits == 7'd32 && allocCode_q == `SIOA_ALLOC_2W))) |=> !linkOkIndicator)
		else $error("slave beyond its node range was served");

	// Placement of four-bit slaves, eight-bit slaves in four-bit mode and the low byte of wide slaves
	AST_NIB_BYTE_MODE: assert property (seqAcceptIn ##0 (!mode4_q && slvBits == 7'd4) |=>
		inByteChk[3:0] == $past(slvInData[3:0]))
		else $error("four-bit slave not in the low nibble of its byte");
	AST_NIB_NIB_MODE: assert property (seqAcceptIn ##0 (mode4_q && slvBits == 7'd4) |=>
		inNibChk[3:0] == $past(slvInData[3:0]))
		else $error("four-bit slave not in its own nibble");
	AST_BYTE_NIB_MODE: assert property (seqAcceptIn ##0 (mode4_q && slvBits == 7'd8) |=>
		inNibChk[7:0] == $past(slvInData[7:0]))
		else $error("eight-bit slave not in two nibbles from its node");
	AST_WIDE_EVEN: assert property (seqAcceptIn ##0 (!mode4_q && slvBits >= 7'd16) |=>
		inWordChk[7:0] == $past(slvInData[7:0]))
		else $error("wide slave does not start at the even node");

	// Startup: no early exit from the delay, and validity holds once reached
	AST_WAIT_FULL: assert property (stateQ == sioa_pkg::ST_WAIT && waitCnt_q > `SIOA_CNT_W'(1) |=>
		stateQ == sioa_pkg::ST_WAIT)
		else $error("startup delay cut short");
	AST_VALID_HOLD: assert property (ioValid |=> ioValid)
		else $error("inputs lost validity without a reset");
	AST_VALID_EVT: assert property ($rose(ioValid) |-> sts_q[`SIOA_STS_VALID])
		else $error("validity event not flagged in status");
	AST_CFG_HOLD: assert property (rst_b && stateQ != sioa_pkg::ST_CAPTURE |=>
		$stable(allocCode_q) && $stable(mode4_q))
		else $error("switch settings changed after startup");

	// Read data stand one cycle only
	AST_RD_IDLE: assert property (!regRd |=> regRdata == 16'h0000)
		else $error("read data without a read strobe");
endmodule : sioa_word_allocator

// ==== dv/sioa_slave_model.sv ====
// Remote slave terminal model: presents one transfer per request from the bench
`timescale 1ns/1ps
module sioa_slave_model (
	input  wire logic        mclk,
	input  wire logic        go,
	input  wire logic        goIsOut,
	input  wire logic [3:0]  goNode,
	input  wire logic [6:0]  goBits,
	input  wire logic [63:0] goData,
	output logic             slvStb,
	output logic             slvIsOut,
	output logic      [3:0]  slvNode,
	output logic      [6:0]  slvBits,
	output logic      [63:0] slvInData
);
	// Idle bus at time zero
	initial begin
		slvStb = 1'b0;
		slvIsOut = 1'b0;
		slvNode = 4'h0;
		slvBits = 7'h08;
		slvInData = 64'h0;
	end
	// Data toggles between frames so a stale word never passes for a fresh one
	always @(posedge mclk) begin
		slvStb <= go;
		if (go) begin
			slvIsOut <= goIsOut;
			slvNode <= goNode;
			slvBits <= goBits;
			slvInData <= goData;
		end else begin
			slvInData <= ~slvInData;
		end
	end
endmodule : sioa_slave_model

// ==== dv/test_slave_io_word_allocator.sv ====
// Self-checking bench for the slave I/O word allocator
`timescale 1ns/1ps
module test_slave_io_word_allocator;
	localparam int FAST = 20;
	localparam int LONG = 40;
	logic        mclk, rst_b, swAllocLo, swAllocHi, swFourPoint, swLongDist, hostCycle;
	logic        regWr, regRd, go, goIsOut, slvStb, slvIsOut, slvAck, linkOkIndicator, ioValid, irq;
	logic [3:0]  regAddr, goNode, slvNode;
	logic [6:0]  goBits, slvBits;
	logic [15:0] regWdata, regRdata;
	logic [63:0] goData, slvInData, slvOutData, slvDriveMask;
	int          nFail, nChecks, cycles;

	sioa_word_allocator #(.FAST_CYCLES(FAST), .LONG_CYCLES(LONG)) i_dut (.mclk(mclk), .rst_b(rst_b),
		.swAllocLo(swAllocLo), .swAllocHi(swAllocHi), .swFourPoint(swFourPoint), .swLongDist(swLongDist),
		.hostCycle(hostCycle), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .slvStb(slvStb), .slvIsOut(slvIsOut), .slvNode(slvNode), .slvBits(slvBits),
		.slvInData(slvInData), .slvOutData(slvOutData), .slvDriveMask(slvDriveMask), .slvAck(slvAck),
		.linkOkIndicator(linkOkIndicator), .ioValid(ioValid), .irq(irq));
	sioa_slave_model i_slave (.mclk(mclk), .go(go), .goIsOut(goIsOut), .goNode(goNode), .goBits(goBits),
		.goData(goData), .slvStb(slvStb), .slvIsOut(slvIsOut), .slvNode(slvNode), .slvBits(slvBits),
		.slvInData(slvInData));

	task endSim;
		if (nFail == 0 && nChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : endSim
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		nChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regWr <= 1'b1; regAddr <= a; regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		regRd <= 1'b1; regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
	endtask : rd
	// Output transfers also check the returned data and drive mask
	task xfer(input logic o, input logic [3:0] n, input logic [6:0] b, input logic [63:0] d, input logic ok);
		int i;
		@(posedge mclk);
		go <= 1'b1; goIsOut <= o; goNode <= n; goBits <= b; goData <= d;
		@(posedge mclk);
		go <= 1'b0;
		for (i = 0; i < 4 && slvAck !== 1'b1; i++) begin @(posedge mclk); #1; end
		chk(slvAck, 1'b1);
		chk(linkOkIndicator, ok);
		if (o) begin chk(slvOutData, ok ? d : 64'h0); chk(slvDriveMask, ok ? (64'h1 << b) - 64'h1 : 64'h0); end
	endtask : xfer
	task rstCfg(input logic lo, input logic hi, input logic m4, input logic ld);
		int i;
		@(posedge mclk);
		swAllocLo <= lo; swAllocHi <= hi; swFourPoint <= m4; swLongDist <= ld; rst_b <= 1'b0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		xfer(1'b0, 4'h0, 7'h08, 64'h0055, 1'b0);
		repeat (ld ? LONG : FAST) @(posedge mclk);
		#1 chk(ioValid, 1'b0);
		@(posedge mclk);
		hostCycle <= 1'b1;
		@(posedge mclk);
		hostCycle <= 1'b0;
		for (i = 0; i < 4 && ioValid !== 1'b1; i++) begin @(posedge mclk); #1; end
		chk(ioValid, 1'b1);
	endtask : rstCfg
	// Every word allocation switch setting, with size limits at the area edge
	task sAlloc;
		int k;
		for (k = 0; k < 4; k++) begin
			rstCfg(k[0], k[1], 1'b0, 1'b0);
			rd(4'hA, k[1] ? 16'h0012 : (k[0] ? 16'h0011 : 16'h0010));
			xfer(1'b0, 4'h1, 7'h20, 64'h8765_4321, k != 0);
			xfer(1'b0, 4'h2, 7'h10, 64'h00aa, k != 0);
		end
	endtask : sAlloc
	task sMap8;
		chk(irq, 1'b0);
		xfer(1'b0, 4'h3, 7'h08, 64'h00a5, 1'b1);
		xfer(1'b0, 4'h2, 7'h08, 64'h003c, 1'b1);
		rd(4'h1, 16'ha53c);
		rd(4'h3, 16'h0000);
		xfer(1'b0, 4'h5, 7'h04, 64'h000f, 1'b1);
		rd(4'h2, 16'h0f00);
		xfer(1'b0, 4'h7, 7'h10, 64'h1234, 1'b1);
		rd(4'h3, 16'h1234);
		xfer(1'b0, 4'h1, 7'h30, 64'h1111_2222_3333, 1'b1);
		rd(4'h2, 16'h1111);
		xfer(1'b0, 4'h3, 7'h40, 64'hffff_ffff_ffff_ffff, 1'b0);
		rd(4'h3, 16'h1234);
		wr(4'h5, 16'h7788);
		xfer(1'b1, 4'h3, 7'h08, 64'h0077, 1'b1);
		rd(4'h1, 16'h2222);
		wr(4'h6, 16'hbeef);
		wr(4'h7, 16'hdead);
		xfer(1'b1, 4'h5, 7'h20, 64'hdead_beef, 1'b1);
		wr(4'h4, 16'h5a5a);
		xfer(1'b1, 4'h1, 7'h10, 64'h5a5a, 1'b1);
		rd(4'h5, 16'h7788);
	endtask : sMap8
	// Exclusion event, masking and write-one-to-clear
	task sIrq;
		chk(irq, 1'b0);
		rd(4'h8, 16'h0003);
		wr(4'h9, 16'h0001);
		@(posedge mclk);
		#1 chk(irq, 1'b1);
		wr(4'h8, 16'h0001);
		@(posedge mclk);
		#1 chk(irq, 1'b0);
		rd(4'h8, 16'h0002);
		wr(4'hA, 16'hffff);
		rd(4'hA, 16'h0012);
		rd(4'hc, 16'h0000);
	endtask : sIrq
	task sMode4;
		rstCfg(1'b0, 1'b0, 1'b1, 1'b1);
		rd(4'hA, 16'h001c);
		xfer(1'b0, 4'h3, 7'h04, 64'h0009, 1'b1);
		xfer(1'b0, 4'h1, 7'h08, 64'h00ab, 1'b1);
		rd(4'h0, 16'h9ab0);
		xfer(1'b0, 4'h3, 7'h08, 64'h00cd, 1'b0);
		wr(4'h4, 16'h0c50);
		xfer(1'b1, 4'h1, 7'h08, 64'h00c5, 1'b1);
		xfer(1'b1, 4'h3, 7'h08, 64'h00c5, 1'b0);
	endtask : sMode4

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Hang guard, well above the longest expected run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin nFail++; endSim; end
	end
	initial begin
		{rst_b, swAllocLo, swAllocHi, swFourPoint, swLongDist, hostCycle, regWr, regRd, go, goIsOut} = 10'h0;
		regAddr = 4'h0; regWdata = 16'h0; goNode = 4'h0; goBits = 7'h08; goData = 64'h0;
		nFail = 0; nChecks = 0; cycles = 0;
		sAlloc;
		sMap8;
		sIrq;
		sMode4;
		endSim;
	end
endmodule : test_slave_io_word_allocator
